// [hdl/uart_flags_pkg.sv]
// Constants, register map and types shared by the serial status block
package uart_flags_pkg;
    // Line timing
    localparam int CLOCK_HZ = 25_000_000;
    localparam int BAUD_RATE = 115_200;
    localparam int IDLE_BITS = 10;
    typedef logic [7:0] bitCount_t;
    typedef logic [11:0] idleCount_t;
    localparam bitCount_t BIT_CYCLES = bitCount_t'(CLOCK_HZ / BAUD_RATE);
    localparam bitCount_t BIT_LAST = bitCount_t'(CLOCK_HZ / BAUD_RATE - 1);
    localparam bitCount_t SAMPLE_EARLY = bitCount_t'(CLOCK_HZ / BAUD_RATE / 2 - 1);
    localparam bitCount_t SAMPLE_MID = bitCount_t'(CLOCK_HZ / BAUD_RATE / 2);
    localparam bitCount_t SAMPLE_LATE = bitCount_t'(CLOCK_HZ / BAUD_RATE / 2 + 1);
    localparam idleCount_t IDLE_CYCLES = idleCount_t'(IDLE_BITS * (CLOCK_HZ / BAUD_RATE));
    localparam idleCount_t IDLE_LAST = idleCount_t'(IDLE_BITS * (CLOCK_HZ / BAUD_RATE) - 1);
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    // Register byte offsets
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL1 = 8'h08;
    localparam logic [7:0] ADDR_CTRL2 = 8'h0C;
    localparam logic [7:0] ADDR_CTRL3 = 8'h10;
    localparam logic [7:0] ADDR_EV_STAT = 8'h14;
    localparam logic [7:0] ADDR_EV_CLR = 8'h18;
    localparam logic [7:0] ADDR_EV_EN = 8'h1C;
    localparam logic [23:0] READ_PAD = 24'h000000;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Field positions
    localparam int C1_NINE = 4;
    localparam int C1_PAR_EN = 1;
    localparam int C1_PAR_ODD = 0;
    localparam int C2_TX_EMPTY_IE = 7;
    localparam int C2_TX_DONE_IE = 6;
    localparam int C2_RX_FULL_IE = 5;
    localparam int C2_IDLE_IE = 4;
    localparam int C3_RX_NINTH = 7;
    localparam int C3_TX_NINTH = 6;
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_RX_FULL = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_NOISE = 2;
    localparam int ST_FRAMING = 1;
    localparam int ST_PARITY = 0;
    localparam int EV_WIDTH = 4;
    localparam int EV_RX = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_ERROR = 2;
    localparam int EV_IDLE = 3;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rxState_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} txState_e;

    // One received character with its error conditions
    typedef struct packed {
        logic [8:0] data;
        logic noise;
        logic framing;
        logic parity;
    } rxChar_s;
endpackage

// [hdl/uart_rx_shifter.sv]
// Receive shifter: synchroniser, triple sampling, framing checks, idle timer
`timescale 1ns/1ps
module uart_rx_shifter import uart_flags_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic rxPin,
    input wire logic nineBit,
    input wire logic parEn,
    input wire logic parOdd,
    output logic charValid,
    output rxChar_s charOut,
    output logic idleTick
);
    logic meta_reg;
    logic sync_reg;
    rxState_e state_reg, state_next;
    bitCount_t cnt_reg, cnt_next;
    logic [3:0] idx_reg, idx_next;
    logic [8:0] data_reg, data_next;
    logic [2:0] smp_reg, smp_next;
    logic noise_reg, noise_next;
    logic perr_reg, perr_next;
    idleCount_t idleCnt_reg, idleCnt_next;
    logic valid_reg, valid_next;
    rxChar_s char_reg, char_next;
    logic tick_reg, tick_next;
    logic cntEnd;
    logic bitVal;
    logic disagree;

    assign cntEnd = cnt_reg == BIT_LAST;
    // Majority of three mid-bit samples; any disagreement counts as noise
    assign bitVal = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2]) | (smp_reg[1] & smp_reg[2]);
    assign disagree = (|smp_reg) & ~(&smp_reg);

    // Next state of the receive shifter
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        data_next = data_reg;
        smp_next = smp_reg;
        noise_next = noise_reg;
        perr_next = perr_reg;
        idleCnt_next = '0;
        valid_next = 1'b0;
        char_next = char_reg;
        tick_next = 1'b0;
        if (state_reg != RX_IDLE) begin
            cnt_next = cntEnd ? '0 : cnt_reg + bitCount_t'(1);
            if (cnt_reg == SAMPLE_EARLY) smp_next[0] = sync_reg;
            if (cnt_reg == SAMPLE_MID) smp_next[1] = sync_reg;
            if (cnt_reg == SAMPLE_LATE) smp_next[2] = sync_reg;
        end
        case (state_reg)
            RX_IDLE: begin
                // Idle timer restarts on every start bit, so it ticks once per quiet spell
                if (sync_reg && idleCnt_reg != IDLE_CYCLES) begin
                    idleCnt_next = idleCnt_reg + idleCount_t'(1);
                end else if (sync_reg) begin
                    idleCnt_next = idleCnt_reg;
                end
                tick_next = sync_reg && idleCnt_reg == IDLE_LAST;
                if (!sync_reg) begin
                    state_next = RX_START;
                    cnt_next = '0;
                    idx_next = '0;
                    data_next = '0;
                    perr_next = 1'b0;
                end
            end
            RX_START: if (cntEnd) begin
                // A start bit that reads high was a glitch
                state_next = bitVal ? RX_IDLE : RX_DATA;
                noise_next = disagree;
            end
            RX_DATA: if (cntEnd) begin
                data_next[idx_reg] = bitVal;
                noise_next = noise_reg | disagree;
                idx_next = idx_reg + 4'h1;
                if (idx_reg == (nineBit ? LAST_BIT_9 : LAST_BIT_8)) begin
                    state_next = parEn ? RX_PARITY : RX_STOP;
                end
            end
            RX_PARITY: if (cntEnd) begin
                perr_next = (^data_reg) ^ bitVal ^ parOdd;
                noise_next = noise_reg | disagree;
                state_next = RX_STOP;
            end
            RX_STOP: if (cntEnd) begin
                valid_next = 1'b1;
                char_next = '{data: data_reg, noise: noise_reg | disagree,
                    framing: ~bitVal, parity: perr_reg};
                state_next = RX_IDLE;
            end
            default: state_next = RX_IDLE;
        endcase
    end

    // Registers; the line idles high so the synchroniser resets to one
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            state_reg <= RX_IDLE;
            cnt_reg <= '0;
            idx_reg <= '0;
            data_reg <= '0;
            smp_reg <= '0;
            noise_reg <= 1'b0;
            perr_reg <= 1'b0;
            idleCnt_reg <= '0;
            valid_reg <= 1'b0;
            char_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            meta_reg <= rxPin;
            sync_reg <= meta_reg;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            data_reg <= data_next;
            smp_reg <= smp_next;
            noise_reg <= noise_next;
            perr_reg <= perr_next;
            idleCnt_reg <= idleCnt_next;
            valid_reg <= valid_next;
            char_reg <= char_next;
            tick_reg <= tick_next;
        end
    end

    assign charValid = valid_reg;
    assign charOut = char_reg;
    assign idleTick = tick_reg;
endmodule

// [hdl/uart_status_flags.sv]
// Serial transceiver status flags, interrupt requests and nine-bit data mode
// Operation
// - Transmit-empty flag; its enable requests interrupt
// - Transmit-complete only when fully sent, line high
// - Flags update regardless of interrupt enables
// - Receive-full clears by status then data read
// - Idle clears by status then data read
// - Idle re-arms only after new received character
// - Error flags set together with receive-full
// - Receive while full sets overrun, drops character
// - No error flags for overrun characters
// - Data-length bit selects nine-bit mode both ways
// - Ninth bits live in third control register
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module uart_status_flags import uart_flags_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serialRxPin,
    output logic serialTxPin,
    output logic irq
);
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
    logic txNinth_reg, txNinth_next, rxNinth_reg, rxNinth_next;
    logic [7:0] rxBuf_reg, rxBuf_next;
    logic [8:0] txBuf_reg, txBuf_next;
    logic txEmpty_reg, txEmpty_next, txDone_reg, txDone_next;
    logic rxFull_reg, rxFull_next, idle_reg, idle_next;
    logic overrun_reg, overrun_next, noise_reg, noise_next;
    logic framing_reg, framing_next, parity_reg, parity_next;
    logic rxSeen_reg, rxSeen_next, idleSeen_reg, idleSeen_next;
    logic idleArmed_reg, idleArmed_next;
    logic [EV_WIDTH-1:0] evStat_reg, evStat_next, evEn_reg, evEn_next;
    logic irq_reg, irq_next;
    txState_e txState_reg, txState_next;
    bitCount_t txCnt_reg, txCnt_next;
    logic [3:0] txIdx_reg, txIdx_next;
    logic [8:0] txShift_reg, txShift_next;
    logic txNine_reg, txNine_next, txPin_reg, txPin_next;
    logic access, busWr, busRd, dataRd, dataWr, rxClear, rxAccept, txTake, txCntEnd;
    logic [7:0] statusByte, wByte;
    logic [EV_WIDTH-1:0] evSet, evClr;
    logic charValid, idleTick;
    rxChar_s rxChar;

    uart_rx_shifter rxShift (
        .clock(clock),
        .reset(reset),
        .rxPin(serialRxPin),
        .nineBit(ctrl1_reg[C1_NINE]),
        .parEn(ctrl1_reg[C1_PAR_EN]),
        .parOdd(ctrl1_reg[C1_PAR_ODD]),
        .charValid(charValid),
        .charOut(rxChar),
        .idleTick(idleTick)
    );

    // Bus request decode; one answer per request, ack drops the cycle after
    assign access = wb_cyc_i && wb_stb_i && !ack_reg;
    assign busWr = access && wb_we_i && wb_sel_i[0];
    assign busRd = access && !wb_we_i;
    assign wByte = wb_dat_i[7:0];
    assign dataRd = busRd && wb_adr_i == ADDR_DATA;
    assign dataWr = busWr && wb_adr_i == ADDR_DATA;
    assign rxClear = dataRd && rxSeen_reg;
    // A new character is taken when the buffer is free or being freed now
    assign rxAccept = charValid && (!rxFull_reg || rxClear);
    assign txTake = txState_reg == TX_IDLE && !txEmpty_reg;
    assign txCntEnd = txCnt_reg == BIT_LAST;

    // Status byte as software sees it
    always_comb begin
        statusByte = '0;
        statusByte[ST_TX_EMPTY] = txEmpty_reg;
        statusByte[ST_TX_DONE] = txDone_reg;
        statusByte[ST_RX_FULL] = rxFull_reg;
        statusByte[ST_IDLE] = idle_reg;
        statusByte[ST_OVERRUN] = overrun_reg;
        statusByte[ST_NOISE] = noise_reg;
        statusByte[ST_FRAMING] = framing_reg;
        statusByte[ST_PARITY] = parity_reg;
    end

    // Registers, flags and events: clears first, then sets so a set wins
    always_comb begin
        ack_next = access;
        rdata_next = '0;
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        txNinth_next = txNinth_reg;
        rxNinth_next = rxNinth_reg;
        rxBuf_next = rxBuf_reg;
        txBuf_next = txBuf_reg;
        txEmpty_next = txEmpty_reg;
        rxFull_next = rxFull_reg;
        idle_next = idle_reg;
        overrun_next = overrun_reg;
        noise_next = noise_reg;
        framing_next = framing_reg;
        parity_next = parity_reg;
        rxSeen_next = rxSeen_reg;
        idleSeen_next = idleSeen_reg;
        idleArmed_next = idleArmed_reg;
        evEn_next = evEn_reg;
        evSet = '0;
        evClr = '0;
        if (busRd) begin
            if (wb_adr_i == ADDR_DATA) begin
                rdata_next = {READ_PAD, rxBuf_reg};
            end else if (wb_adr_i == ADDR_STATUS1) begin
                rdata_next = {READ_PAD, statusByte};
            end else if (wb_adr_i == ADDR_CTRL1) begin
                rdata_next = {READ_PAD, ctrl1_reg};
            end else if (wb_adr_i == ADDR_CTRL2) begin
                rdata_next = {READ_PAD, ctrl2_reg};
            end else if (wb_adr_i == ADDR_CTRL3) begin
                rdata_next[C3_RX_NINTH] = rxNinth_reg;
                rdata_next[C3_TX_NINTH] = txNinth_reg;
            end else if (wb_adr_i == ADDR_EV_STAT) begin
                rdata_next[EV_WIDTH-1:0] = evStat_reg;
            end else if (wb_adr_i == ADDR_EV_EN) begin
                rdata_next[EV_WIDTH-1:0] = evEn_reg;
            end
        end
        if (busWr) begin
            if (wb_adr_i == ADDR_CTRL1) begin
                ctrl1_next = wByte;
            end else if (wb_adr_i == ADDR_CTRL2) begin
                ctrl2_next = wByte;
            end else if (wb_adr_i == ADDR_CTRL3) begin
                txNinth_next = wByte[C3_TX_NINTH];
            end else if (wb_adr_i == ADDR_EV_CLR) begin
                evClr = wByte[EV_WIDTH-1:0];
            end else if (wb_adr_i == ADDR_EV_EN) begin
                evEn_next = wByte[EV_WIDTH-1:0];
            end
        end
        // Status read arms the clear of the flags it saw set
        if (busRd && wb_adr_i == ADDR_STATUS1) begin
            rxSeen_next = rxFull_reg;
            idleSeen_next = idle_reg;
        end
        if (dataRd) begin
            rxSeen_next = 1'b0;
            idleSeen_next = 1'b0;
            if (rxSeen_reg) begin
                rxFull_next = 1'b0;
                overrun_next = 1'b0;
                noise_next = 1'b0;
                framing_next = 1'b0;
                parity_next = 1'b0;
            end
            if (idleSeen_reg) idle_next = 1'b0;
        end
        // Writes while the buffer is full are dropped
        if (dataWr && txEmpty_reg) begin
            txBuf_next = {ctrl1_reg[C1_NINE] & txNinth_reg, wByte};
            txEmpty_next = 1'b0;
        end
        if (txTake) txEmpty_next = 1'b1;
        if (rxAccept) begin
            rxFull_next = 1'b1;
            rxBuf_next = rxChar.data[7:0];
            if (ctrl1_reg[C1_NINE]) rxNinth_next = rxChar.data[8];
            noise_next = rxChar.noise;
            framing_next = rxChar.framing;
            parity_next = rxChar.parity;
            idleArmed_next = 1'b1;
            evSet[EV_RX] = 1'b1;
            evSet[EV_ERROR] = rxChar.noise | rxChar.framing | rxChar.parity;
        end else if (charValid) begin
            overrun_next = 1'b1;
            evSet[EV_OVERRUN] = 1'b1;
        end
        if (idleTick && idleArmed_reg) begin
            idle_next = 1'b1;
            idleArmed_next = 1'b0;
            evSet[EV_IDLE] = 1'b1;
        end
        // Done only with nothing queued, shifter idle and line resting high
        // Look at the shifter's next state so a pending take never shows as done
        txDone_next = txState_next == TX_IDLE && txEmpty_next && txPin_next;
        evStat_next = (evStat_reg & ~evClr) | evSet;
        // Enables gate only the request line, never the flags
        irq_next = (txEmpty_next & ctrl2_next[C2_TX_EMPTY_IE])
            | (txDone_next & ctrl2_next[C2_TX_DONE_IE])
            | (rxFull_next & ctrl2_next[C2_RX_FULL_IE])
            | (idle_next & ctrl2_next[C2_IDLE_IE])
            | (|(evStat_next & evEn_next));
    end

    // Transmit shifter: start, data bits LSB first, optional parity, stop
    always_comb begin
        txState_next = txState_reg;
        txCnt_next = txCnt_reg;
        txIdx_next = txIdx_reg;
        txShift_next = txShift_reg;
        txNine_next = txNine_reg;
        txPin_next = txPin_reg;
        if (txState_reg != TX_IDLE) txCnt_next = txCntEnd ? '0 : txCnt_reg + bitCount_t'(1);
        case (txState_reg)
            TX_IDLE: begin
                txPin_next = 1'b1;
                if (txTake) begin
                    txShift_next = txBuf_reg;
                    txNine_next = ctrl1_reg[C1_NINE];
                    txState_next = TX_START;
                    txCnt_next = '0;
                    txIdx_next = '0;
                    txPin_next = 1'b0;
                end
            end
            TX_START: if (txCntEnd) begin
                txState_next = TX_DATA;
                txPin_next = txShift_reg[0];
            end
            TX_DATA: if (txCntEnd) begin
                if (txIdx_reg == (txNine_reg ? LAST_BIT_9 : LAST_BIT_8)) begin
                    txState_next = ctrl1_reg[C1_PAR_EN] ? TX_PARITY : TX_STOP;
                    txPin_next = ctrl1_reg[C1_PAR_EN] ?
                        (^txShift_reg) ^ ctrl1_reg[C1_PAR_ODD] : 1'b1;
                end else begin
                    txIdx_next = txIdx_reg + 4'h1;
                    txPin_next = txShift_reg[txIdx_next];
                end
            end
            TX_PARITY: if (txCntEnd) begin
                txState_next = TX_STOP;
                txPin_next = 1'b1;
            end
            TX_STOP: if (txCntEnd) txState_next = TX_IDLE;
            default: txState_next = TX_IDLE;
        endcase
    end

    // All state registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
            ctrl1_reg <= CTRL_RESET;
            ctrl2_reg <= CTRL_RESET;
            txNinth_reg <= 1'b0;
            rxNinth_reg <= 1'b0;
            rxBuf_reg <= '0;
            txBuf_reg <= '0;
            txEmpty_reg <= 1'b1;
            txDone_reg <= 1'b1;
            rxFull_reg <= 1'b0;
            idle_reg <= 1'b0;
            overrun_reg <= 1'b0;
            noise_reg <= 1'b0;
            framing_reg <= 1'b0;
            parity_reg <= 1'b0;
            rxSeen_reg <= 1'b0;
            idleSeen_reg <= 1'b0;
            idleArmed_reg <= 1'b0;
            evStat_reg <= '0;
            evEn_reg <= '0;
            irq_reg <= 1'b0;
            txState_reg <= TX_IDLE;
            txCnt_reg <= '0;
            txIdx_reg <= '0;
            txShift_reg <= '0;
            txNine_reg <= 1'b0;
            txPin_reg <= 1'b1;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
            txNinth_reg <= txNinth_next;
            rxNinth_reg <= rxNinth_next;
            rxBuf_reg <= rxBuf_next;
            txBuf_reg <= txBuf_next;
            txEmpty_reg <= txEmpty_next;
            txDone_reg <= txDone_next;
            rxFull_reg <= rxFull_next;
            idle_reg <= idle_next;
            overrun_reg <= overrun_next;
            noise_reg <= noise_next;
            framing_reg <= framing_next;
            parity_reg <= parity_next;
            rxSeen_reg <= rxSeen_next;
            idleSeen_reg <= idleSeen_next;
            idleArmed_reg <= idleArmed_next;
            evStat_reg <= evStat_next;
            evEn_reg <= evEn_next;
            irq_reg <= irq_next;
            txState_reg <= txState_next;
            txCnt_reg <= txCnt_next;
            txIdx_reg <= txIdx_next;
            txShift_reg <= txShift_next;
            txNine_reg <= txNine_next;
            txPin_reg <= txPin_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign serialTxPin = txPin_reg;
    assign irq = irq_reg;

    // Checks on flag and request behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    tx_empty_irq_a: assert property (txEmpty_reg && ctrl2_reg[C2_TX_EMPTY_IE] |-> irq)
        else $error("transmit-empty request missing");
    tx_done_line_a: assert property (txDone_reg |-> txPin_reg && txState_reg == TX_IDLE
        && txEmpty_reg)
        else $error("transmit-complete while busy");
    flag_unmasked_a: assert property (charValid && !rxFull_reg && !ctrl2_reg[C2_RX_FULL_IE]
        |=> rxFull_reg)
        else $error("receive-full not set while masked");
    rx_clear_a: assert property ($fell(rxFull_reg) |-> $past(dataRd) && $past(rxSeen_reg))
        else $error("receive-full cleared without sequence");
    idle_clear_a: assert property ($fell(idle_reg) |-> $past(dataRd) && $past(idleSeen_reg))
        else $error("idle cleared without sequence");
    idle_rearm_a: assert property ($rose(idle_reg) |-> $past(idleArmed_reg))
        else $error("idle set without new character");
    err_with_full_a: assert property ($rose(noise_reg || framing_reg || parity_reg)
        |-> $rose(rxFull_reg) || $past(rxClear))
        else $error("error flag without receive-full");
    overrun_drop_a: assert property (charValid && rxFull_reg && !rxClear
        |=> overrun_reg && $stable(rxBuf_reg) && $stable(noise_reg))
        else $error("overrun character not dropped");
    ninth_store_a: assert property (rxAccept |=> rxNinth_reg == ($past(ctrl1_reg[C1_NINE])
        ? $past(rxChar.data[8]) : $past(rxNinth_reg)))
        else $error("received ninth bit mishandled");
    rx_irq_a: assert property (rxFull_reg && ctrl2_reg[C2_RX_FULL_IE] |-> irq)
        else $error("receive request missing");

    overrun_seen_c: cover property (charValid && rxFull_reg && !rxClear);
    idle_seen_c: cover property ($rose(idle_reg));
    tx_done_c: cover property ($rose(txDone_reg));
    nine_rx_c: cover property (rxAccept && ctrl1_reg[C1_NINE] && rxChar.data[8]);
endmodule

// [tb/uart_line_model.sv]
// Remote serial transceiver model on the line
`timescale 1ns/1ps
module uart_line_model (
    input wire logic clock,
    input wire logic txLine,
    output logic rxLine
);
    localparam int BIT = 217;
    logic [8:0] lastRx;
    initial rxLine = 1'b1;
    // Start bit, n bits LSB first, chosen stop level, one idle bit
    task automatic sendChar(input logic [8:0] d, input int n, input logic stopBit);
        rxLine <= 1'b0;
        repeat (BIT) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            rxLine <= d[i];
            repeat (BIT) @(posedge clock);
        end
        rxLine <= stopBit;
        repeat (BIT) @(posedge clock);
        rxLine <= 1'b1;
        repeat (BIT) @(posedge clock);
    endtask
    // Samples mid-bit after the start edge; returns mid stop bit
    task automatic recvChar(input int n);
        lastRx = '0;
        @(negedge txLine);
        repeat (BIT + BIT / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            lastRx[i] = txLine;
            repeat (BIT) @(posedge clock);
        end
    endtask
endmodule

// [tb/uart_status_flags_bench.sv]
// Self-checking bench for the serial status flag block
`timescale 1ns/1ps
module uart_status_flags_bench import uart_flags_pkg::*; ;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
    logic clock, reset, cyc, stb, we, ack, rxPin, txPin, irq;
    logic [7:0] adr, rd;
    logic [31:0] wdat, rdat;
    int failures, compares;
    row_s rows[9] = '{
        '{1'b0, 8'h04, 8'h00, 8'hC0}, '{1'b0, 8'h08, 8'h00, 8'h00},
        '{1'b0, 8'h0C, 8'h00, 8'h00}, '{1'b0, 8'h14, 8'h00, 8'h00},
        '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b1, 8'h0C, 8'h80, 8'h01},
        '{1'b0, 8'h04, 8'h00, 8'hC0}, '{1'b1, 8'h0C, 8'h40, 8'h01},
        '{1'b1, 8'h0C, 8'h00, 8'h00}};
    uart_status_flags i_dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .serialRxPin(rxPin), .serialTxPin(txPin), .irq(irq));
    uart_line_model i_line (.clock(clock), .txLine(txPin), .rxLine(rxPin));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Ends the run at 60000 cycles, over twice the full test, so a hung slave fails
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        results();
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        compares++;
        if (got !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask
    // Classic cycle held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clock);
        // No fixed wait: only the watchdog ends a hung cycle
        while (ack !== 1'b1) @(posedge clock);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset, register table, then receive, overrun, nine-bit, parity and mid-run reset cases
    initial begin
        {cyc, stb, we, adr, wdat} = '0;
        reset = 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (rows[i].w) chk("irq", rows[i].e, {7'h00, irq});
            else chk("reg", rows[i].e, rd);
        end
        $display("test table done");
        i_line.sendChar(9'h0A5, 8, 1'b1);
        rdChk(ADDR_STATUS1, 8'hE0);
        rdChk(ADDR_DATA, 8'hA5);
        rdChk(ADDR_STATUS1, 8'hC0);
        repeat (2400) @(posedge clock);
        rdChk(ADDR_STATUS1, 8'hD0);
        wb(1'b0, ADDR_DATA, 8'h00);
        repeat (2400) @(posedge clock);
        rdChk(ADDR_STATUS1, 8'hC0);
        $display("test receive done");
        i_line.sendChar(9'h011, 8, 1'b1);
        i_line.sendChar(9'h022, 8, 1'b0);
        rdChk(ADDR_STATUS1, 8'hE8);
        rdChk(ADDR_DATA, 8'h11);
        i_line.sendChar(9'h033, 8, 1'b0);
        rdChk(ADDR_STATUS1, 8'hE2);
        rdChk(ADDR_DATA, 8'h33);
        $display("test overrun done");
        wb(1'b1, ADDR_CTRL1, 8'h10);
        i_line.sendChar(9'h1A5, 9, 1'b1);
        rdChk(ADDR_CTRL3, 8'h80);
        rdChk(ADDR_STATUS1, 8'hE0);
        rdChk(ADDR_DATA, 8'hA5);
        wb(1'b1, ADDR_CTRL3, 8'h40);
        fork
            i_line.recvChar(9);
            wb(1'b1, ADDR_DATA, 8'h5A);
        join
        chk("tx data", 8'h5A, i_line.lastRx[7:0]);
        chk("tx ninth", 8'h01, {7'h00, i_line.lastRx[8]});
        repeat (300) @(posedge clock);
        rdChk(ADDR_STATUS1, 8'hD0);
        wb(1'b0, ADDR_DATA, 8'h00);
        wb(1'b1, ADDR_CTRL1, 8'h00);
        i_line.sendChar(9'h0F0, 8, 1'b1);
        rdChk(ADDR_CTRL3, 8'hC0);
        $display("test nine bit done");
        rdChk(ADDR_STATUS1, 8'hE0);
        rdChk(ADDR_DATA, 8'hF0);
        wb(1'b1, ADDR_CTRL1, 8'h02);
        wb(1'b1, ADDR_CTRL2, 8'h20);
        // Even parity; the ninth bit sent is a wrong parity bit for 0x03
        i_line.sendChar(9'h103, 9, 1'b1);
        chk("irq", 8'h01, {7'h00, irq});
        rdChk(ADDR_STATUS1, 8'hE1);
        rdChk(ADDR_DATA, 8'h03);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test parity done");
        // Mid-run reset must bring back the reset view
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rdChk(ADDR_STATUS1, 8'hC0);
        rdChk(ADDR_CTRL2, 8'h00);
        rdChk(ADDR_CTRL3, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test reset done");
        results();
    end
endmodule
